// [include/pdml_pkg.sv]
package pdml_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [11:0] cpu_control_status_addr = 12'h000;
	localparam logic [11:0] pd_status_addr = 12'h004;
	localparam logic [11:0] irq_enable_addr = 12'h008;
	localparam logic [31:0] cpu_control_status_reset = 32'h0000_0000;
	localparam logic [31:0] irq_enable_reset = 32'h0000_0000;

	// ****************************************
	// Field layout
	// ****************************************
	localparam int power_down_field_lsb = 10;
	localparam int power_down_field_msb = 15;
	localparam int gie_bit = 0;
	localparam int nonmaskable_irq_enable_bit = 1;

	// ****************************************
	// Field encodings
	// ****************************************
	localparam logic [5:0] power_down_field_none = 6'h00;
	localparam logic [5:0] power_down_field_halt_enabled = 6'h09;
	localparam logic [5:0] power_down_field_halt_any = 6'h11;
	localparam logic [5:0] power_down_field_pll_out = 6'h1a;
	localparam logic [5:0] power_down_field_pll_in = 6'h1c;

	// ****************************************
	// Timing
	// ****************************************
	localparam logic [3:0] entry_delay_cycles = 4'h9;
	localparam int pll_lock_us = 75;
	localparam int clk_mhz = 50;
	localparam int pll_lock_cycles = pll_lock_us * clk_mhz;
	localparam logic [3:0] wake_pulse_cycles = 4'h1;

	typedef enum logic [2:0] {
		pdml_run = 3'b000,
		pdml_arm = 3'b001,
		pdml_halt = 3'b011,
		pdml_wake = 3'b010,
		pdml_deep = 3'b110,
		pdml_lock = 3'b100
	} pdml_state_t;

	typedef struct packed {
		logic cpu_clock_enable;
		logic dma_clock_enable;
		logic pll_output_enable;
		logic pll_input_enable;
		logic io_freeze;
	} pdml_clk_t;

	typedef struct packed {
		logic service_request;
		logic resume;
	} pdml_wake_t;
endpackage

// [hw/pdml_delay.sv]
module pdml_delay (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Control
	input wire logic start,
	input wire logic clear,
	input wire logic [15:0] load,
	output logic done
);
	logic [15:0] count;
	logic busy;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 16'h0000;
			busy <= 1'b0;
			done <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (clear) begin
				busy <= 1'b0;
				count <= 16'h0000;
			end else if (start) begin
				busy <= 1'b1;
				count <= load;
			end else if (busy) begin
				if (count <= 16'h0001) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					count <= count - 16'h0001;
				end
			end
		end
	end
endmodule

// [hw/pdml_top.sv]
// Functional notes
// - Field bits 15..10 select mode and wake
// - Mode takes effect nine cycles after write
// - 001001 halts; enabled interrupt wakes
// - 010001 halts; any interrupt wakes
// - Light mode gates CPU clock, not interrupts
// - DMA clock keeps running in light mode
// - Non-enabled wake resumes without service
// - Enabled wake runs service then resumes
// - Service needs global and nonmaskable enables
// - 011010 stops PLL output clock
// - 011100 stops PLL input clock
// - Deep modes end only on reset
// - Deep modes keep register and RAM contents
// - Deep modes freeze functional outputs
// - Async peripherals unaffected, out of spec
// - After input-stop reset wait PLL lock
// - Only reference clock input is gated
module pdml_top #(
	parameter int lock_cycles = pdml_pkg::pll_lock_cycles
) (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt sources, raw and after enable masking
	input wire logic irq_pending,
	input wire logic irq_enabled_pending,
	// Clock tree controls
	output logic cpu_clock_enable,
	output logic dma_clock_enable,
	output logic pll_output_enable,
	output logic pll_input_enable,
	output logic io_freeze,
	output logic cpu_ready,
	// Wake signalling to the CPU
	output logic service_request,
	output logic resume
);
	// ****************************************
	// Registers
	// ****************************************
	logic [31:0] cpu_control_status;
	logic [31:0] irq_enable_register;
	pdml_pkg::pdml_state_t state;
	pdml_pkg::pdml_state_t next_state;
	logic [5:0] armed_field;
	logic [3:0] arm_count;
	logic lock_start;
	logic lock_done;
	logic pll_in_reset_seen;
	logic wr;
	logic rd;
	logic [5:0] field;
	logic wake_now;

	// Address decode, shared by read mux, error flag and write enables
	logic hit_csr;
	logic hit_status;
	logic hit_irq_en;
	logic addr_hit;
	logic [31:0] next_prdata;
	logic [31:0] next_cpu_control_status;

	// Next clock controls and wake pulses travel together
	pdml_pkg::pdml_clk_t next_clk;
	pdml_pkg::pdml_wake_t next_wake;

	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign field = cpu_control_status[pdml_pkg::power_down_field_msb:pdml_pkg::power_down_field_lsb];

	// ****************************************
	// Address decode
	// ****************************************
	assign hit_csr = paddr == pdml_pkg::cpu_control_status_addr;
	assign hit_status = paddr == pdml_pkg::pd_status_addr;
	assign hit_irq_en = paddr == pdml_pkg::irq_enable_addr;
	assign addr_hit = hit_csr || hit_status || hit_irq_en;

	// ****************************************
	// APB slave
	// ****************************************
	// Read data is picked in the setup cycle so prdata can come from a flop
	always_comb begin
		next_prdata = 32'h0000_0000;
		if (hit_csr) begin
			next_prdata = cpu_control_status;
		end else if (hit_irq_en) begin
			next_prdata = irq_enable_register;
		end else if (hit_status) begin
			next_prdata = {23'h00_0000, lock_start, state, armed_field[4:0]};
		end
	end

	// Zero wait states: pready high in every access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			pready <= psel && !penable;
			// Unmapped reads return zero with an error; writes there are dropped
			pslverr <= psel && !penable && !addr_hit;
			if (rd) begin
				prdata <= next_prdata;
			end
		end
	end

	// Whole-word write only, so the field always changes in one step
	always_comb begin
		next_cpu_control_status = cpu_control_status;
		if (wr && pready && hit_csr) begin
			next_cpu_control_status = pwdata;
		end else if (state == pdml_pkg::pdml_wake) begin
			// Field returns to run once light mode ends, so it does not re-enter
			next_cpu_control_status[pdml_pkg::power_down_field_msb:pdml_pkg::power_down_field_lsb] = pdml_pkg::power_down_field_none;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_control_status <= pdml_pkg::cpu_control_status_reset;
		end else if (ce) begin
			cpu_control_status <= next_cpu_control_status;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable_register <= pdml_pkg::irq_enable_reset;
		end else if (ce && wr && pready && hit_irq_en) begin
			irq_enable_register <= pwdata;
		end
	end

	// ****************************************
	// Entry delay and mode decode
	// ****************************************
	// Mode latched on entry so the gates below decode one stable value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_field <= pdml_pkg::power_down_field_none;
		end else if (ce && state == pdml_pkg::pdml_run && field != pdml_pkg::power_down_field_none) begin
			armed_field <= field;
		end
	end

	// Entry countdown, loaded on the first run cycle that sees a field
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arm_count <= 4'h0;
		end else if (ce) begin
			if (state == pdml_pkg::pdml_run && field != pdml_pkg::power_down_field_none) begin
				arm_count <= pdml_pkg::entry_delay_cycles;
			end else if (state == pdml_pkg::pdml_arm && arm_count != 4'h0) begin
				arm_count <= arm_count - 4'h1;
			end
		end
	end

	assign wake_now = (armed_field == pdml_pkg::power_down_field_halt_enabled) ? irq_enabled_pending
		: irq_pending;

	always_comb begin
		next_state = state;
		case (state)
			pdml_pkg::pdml_run: begin
				if (field != pdml_pkg::power_down_field_none) begin
					next_state = pdml_pkg::pdml_arm;
				end
			end
			pdml_pkg::pdml_arm: begin
				// Decode and the clock flop cost two cycles, so leave two counts early
				// to keep the gate inside the nine-cycle entry window
				if (arm_count <= 4'h2) begin
					case (armed_field)
						pdml_pkg::power_down_field_halt_enabled,
						pdml_pkg::power_down_field_halt_any: next_state = pdml_pkg::pdml_halt;
						pdml_pkg::power_down_field_pll_out,
						pdml_pkg::power_down_field_pll_in: next_state = pdml_pkg::pdml_deep;
						default: next_state = pdml_pkg::pdml_arm;
					endcase
				end
				if (field == pdml_pkg::power_down_field_none || field != armed_field) begin
					next_state = pdml_pkg::pdml_run;
				end
			end
			pdml_pkg::pdml_halt: begin
				if (wake_now) begin
					next_state = pdml_pkg::pdml_wake;
				end
			end
			pdml_pkg::pdml_wake: next_state = pdml_pkg::pdml_run;
			pdml_pkg::pdml_deep: next_state = pdml_pkg::pdml_deep;
			pdml_pkg::pdml_lock: begin
				if (lock_done) begin
					next_state = pdml_pkg::pdml_run;
				end
			end
			default: next_state = pdml_pkg::pdml_run;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= pdml_pkg::pdml_lock;
		end else if (ce) begin
			state <= next_state;
		end
	end

	// ****************************************
	// PLL relock after reset
	// ****************************************
	// Every reset is treated as power-up, covering the input-stop wake too
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_in_reset_seen <= 1'b0;
			lock_start <= 1'b0;
		end else if (ce) begin
			pll_in_reset_seen <= 1'b1;
			lock_start <= !pll_in_reset_seen;
		end
	end

	pdml_delay u_lock (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.start(lock_start),
		.clear(1'b0),
		.load(16'(lock_cycles)),
		.done(lock_done)
	);

	// ****************************************
	// Clock controls
	// ****************************************
	// Only the reference clock path is gated; other input clocks bypass us
	// Gates follow next_state so they switch on the same edge as the state
	always_comb begin
		// Light mode stops CPU core clock; interrupt logic is outside the gate
		next_clk.cpu_clock_enable = !(next_state == pdml_pkg::pdml_halt
			|| next_state == pdml_pkg::pdml_deep);
		next_clk.dma_clock_enable = next_state != pdml_pkg::pdml_deep;
		next_clk.pll_output_enable = !(next_state == pdml_pkg::pdml_deep
			&& armed_field == pdml_pkg::power_down_field_pll_out);
		next_clk.pll_input_enable = !(next_state == pdml_pkg::pdml_deep
			&& armed_field == pdml_pkg::power_down_field_pll_in);
		// Freeze holds outputs and state; nothing is cleared
		// Async peripherals are not behind this freeze
		next_clk.io_freeze = next_state == pdml_pkg::pdml_deep;
	end

	// Core and DMA gates
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_clock_enable <= 1'b1;
			dma_clock_enable <= 1'b1;
		end else if (ce) begin
			cpu_clock_enable <= next_clk.cpu_clock_enable;
			dma_clock_enable <= next_clk.dma_clock_enable;
		end
	end

	// PLL gates; once low they only come back through reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_output_enable <= 1'b1;
			pll_input_enable <= 1'b1;
		end else if (ce) begin
			pll_output_enable <= next_clk.pll_output_enable;
			pll_input_enable <= next_clk.pll_input_enable;
		end
	end

	// Output freeze and CPU run permission
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_freeze <= 1'b0;
			cpu_ready <= 1'b0;
		end else if (ce) begin
			io_freeze <= next_clk.io_freeze;
			cpu_ready <= next_state != pdml_pkg::pdml_lock;
		end
	end

	// ****************************************
	// Wake signalling
	// ****************************************
	// Service needs both enables; without them the CPU only resumes
	always_comb begin
		next_wake.resume = state == pdml_pkg::pdml_halt && wake_now;
		next_wake.service_request = state == pdml_pkg::pdml_halt && irq_enabled_pending
			&& cpu_control_status[pdml_pkg::gie_bit]
			&& irq_enable_register[pdml_pkg::nonmaskable_irq_enable_bit];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resume <= 1'b0;
		end else if (ce) begin
			resume <= next_wake.resume;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			service_request <= 1'b0;
		end else if (ce) begin
			service_request <= next_wake.service_request;
		end
	end
endmodule

// [verification/pdml_props.sv]
module pdml_props (
	// Clock, reset and APB
	input wire logic pclk, presetn, psel, penable, pwrite, pready,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// Clock controls and wake pulses
	input wire logic cpu_clock_enable, dma_clock_enable, pll_output_enable, pll_input_enable,
	input wire logic io_freeze, cpu_ready, service_request, resume
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_wr(logic [5:0] f);
		psel && penable && pready && pwrite && paddr == pdml_pkg::cpu_control_status_addr
			&& pwdata[15:10] == f;
	endsequence
	sequence s_rel;
		$rose(presetn);
	endsequence
	property p_entry;
		s_wr(pdml_pkg::power_down_field_halt_any) |-> ##[1:10] !cpu_clock_enable;
	endproperty
	a_entry: assert property (p_entry) else $error("halt late");
	property p_rsv;
		s_wr(6'h01) |=> cpu_clock_enable [*8];
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved value stopped clock");
	property p_dma;
		!cpu_clock_enable && !io_freeze |-> dma_clock_enable && pll_output_enable;
	endproperty
	a_dma: assert property (p_dma) else $error("light mode stopped dma");
	property p_deep;
		io_freeze |-> !cpu_clock_enable && !dma_clock_enable
			&& !(pll_output_enable && pll_input_enable);
	endproperty
	a_deep: assert property (p_deep) else $error("deep mode clocks run");
	property p_stay;
		io_freeze |=> io_freeze;
	endproperty
	a_stay: assert property (p_stay) else $error("deep mode left");
	property p_wake;
		resume |-> cpu_clock_enable && !$past(cpu_clock_enable);
	endproperty
	a_wake: assert property (p_wake) else $error("resume without halt");
	property p_svc;
		service_request |-> resume;
	endproperty
	a_svc: assert property (p_svc) else $error("service without resume");
	property p_rst;
		s_rel |-> cpu_clock_enable && pll_input_enable && pll_output_enable && !io_freeze;
	endproperty
	a_rst: assert property (p_rst) else $error("clocks not restored");
	property p_lock;
		s_rel |-> !cpu_ready [*8];
	endproperty
	a_lock: assert property (p_lock) else $error("cpu ran before lock");
endmodule

// [verification/pdml_irq_model.sv]
module pdml_irq_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Requested lines and answer delay
	input wire logic [1:0] cmd,
	input wire logic [3:0] lag,
	// Interrupt lines
	output logic irq_pending,
	output logic irq_enabled_pending
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	logic [1:0] want;
	// An enabled interrupt is always pending as well
	assign want = {cmd[1], |cmd};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
			{irq_enabled_pending, irq_pending} <= 2'h0;
		end else if ({irq_enabled_pending, irq_pending} == want) begin
			cnt <= 4'h0;
		end else if (cnt < lag) begin
			cnt <= cnt + 4'h1;
		end else begin
			{irq_enabled_pending, irq_pending} <= want;
			cnt <= 4'h0;
		end
	end
endmodule

// [verification/power_down_mode_logic_tb.sv]
module power_down_mode_logic_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_pending, irq_enabled_pending;
	logic cpu_clock_enable, dma_clock_enable, pll_output_enable, pll_input_enable, io_freeze;
	logic cpu_ready, service_request, resume, ce;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [1:0] irq_cmd;
	logic [3:0] lag;
	logic [7:0] rnd;
	logic [8:0] c;
	logic [32:0] rd_q[$];
	logic wake_q[$];
	wire logic [2:0] obs;
	int num_errors, compares;
	localparam logic [8:0] cases [3] = '{{6'h09, 3'h7}, {6'h11, 3'h4}, {6'h09, 3'h2}};
	assign obs = {cpu_ready, io_freeze, cpu_clock_enable};
	pdml_top #(.lock_cycles(8)) dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq_pending(irq_pending),
		.irq_enabled_pending(irq_enabled_pending), .cpu_clock_enable(cpu_clock_enable),
		.dma_clock_enable(dma_clock_enable), .pll_output_enable(pll_output_enable),
		.pll_input_enable(pll_input_enable), .io_freeze(io_freeze), .cpu_ready(cpu_ready),
		.service_request(service_request), .resume(resume));
	pdml_irq_model u_irq (.pclk(pclk), .presetn(presetn), .cmd(irq_cmd), .lag(lag),
		.irq_pending(irq_pending), .irq_enabled_pending(irq_enabled_pending));
	initial begin
		pclk = 0;
		forever #10 pclk = ~pclk;
	end
	function automatic logic [7:0] lfsr(logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk(string n, logic [32:0] e, logic [32:0] g);
		compares++;
		if (e !== g) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic final_report;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic await(int i, logic v);
		int n;
		n = 0;
		while (obs[i] !== v && n < 40) begin
			@(posedge pclk);
			n++;
		end
		if (obs[i] !== v) begin
			chk("wait", 33'h0_0000_0001, 33'h0_0000_0000);
			final_report;
		end
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1 && n < 20);
		if (n >= 20) begin
			chk("pready", 33'h0_0000_0001, 33'h0_0000_0000);
			final_report;
		end
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rd(logic [11:0] a, logic [32:0] e);
		rd_q.push_back(e);
		apb(0, a, 32'h0000_0000);
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) chk("read", rd_q.pop_front(), {pslverr, prdata});
		if (resume === 1) chk("service", wake_q.size() ? wake_q.pop_front() : 1'bx, service_request);
	end
	initial begin
		presetn = 0;
		{psel, penable, pwrite, paddr, pwdata, irq_cmd, lag} = '0;
		ce = 1;
		rnd = 8;
		repeat (8) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk("clocks", 4'hf, {cpu_clock_enable, dma_clock_enable, pll_output_enable, pll_input_enable});
		rd(pdml_pkg::cpu_control_status_addr, {1'h0, pdml_pkg::cpu_control_status_reset});
		rd(pdml_pkg::irq_enable_addr, {1'h0, pdml_pkg::irq_enable_reset});
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			rd(12'h00c + {rnd[5:0], 2'h0}, 33'h1_0000_0000);
		end
		apb(1, pdml_pkg::irq_enable_addr, 32'h0000_0002);
		// Light halt: enabled-only, any, and enabled with the global enable off
		for (int i = 0; i < 3; i++) begin
			c = cases[i];
			apb(1, 12'h000, {16'h0000, c[8:3], 9'h000, c[2]});
			await(0, 0);
			chk("light", 3'h7, {dma_clock_enable, pll_output_enable, pll_input_enable});
			rnd = lfsr(rnd);
			lag <= {2'h0, rnd[1:0]};
			if (c[8:3] == pdml_pkg::power_down_field_halt_enabled) begin
				irq_cmd <= 2'h1;
				repeat (8) @(posedge pclk);
				chk("halt", 1'h0, cpu_clock_enable);
			end
			wake_q.push_back(c[0]);
			irq_cmd <= c[1] ? 2'h2 : 2'h1;
			await(0, 1);
			irq_cmd <= 2'h0;
			repeat (8) @(posedge pclk);
		end
		apb(1, 12'h000, 32'h0000_0400);
		repeat (15) @(posedge pclk);
		chk("reserved", 1'h1, cpu_clock_enable);
		apb(1, 12'h000, 32'h0000_0000);
		// Deep modes leave only through reset
		for (int i = 0; i < 2; i++) begin
			apb(1, 12'h000, {16'h0000, i ? pdml_pkg::power_down_field_pll_in : pdml_pkg::power_down_field_pll_out, 10'h000});
			await(1, 1);
			chk("pll", 1'h0, i ? pll_input_enable : pll_output_enable);
			irq_cmd <= 2'h2;
			repeat (12) @(posedge pclk);
			chk("deep", 2'h2, {io_freeze, cpu_clock_enable});
			irq_cmd <= 2'h0;
			presetn <= 0;
			@(posedge pclk);
			presetn <= 1;
			@(posedge pclk);
			chk("restore", 5'h1e, {obs[0], dma_clock_enable, pll_output_enable, pll_input_enable, io_freeze});
			chk("ready", 1'h0, cpu_ready);
			// A low clock enable must hold the lock countdown
			ce <= 0;
			repeat (20) @(posedge pclk);
			chk("freeze", 1'h0, cpu_ready);
			ce <= 1;
			await(2, 1);
			rd(12'h000, 33'h0_0000_0000);
		end
		final_report;
	end
endmodule
bind pdml_top pdml_props u_props (.*);
